// >>> rtl/dpr_pkg.sv
// Purpose: shared constants and types of the dual-port memory block
// Assumes: one system clock, registers on a 32-bit AXI4-Lite slave
// Notes: byte addresses of the register words sit in 8 address bits
package dpr_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] DPR_CTRL_OFS = 8'h00;
  localparam logic [7:0] DPR_STATUS_OFS = 8'h04;
  localparam logic [7:0] DPR_WRCNT_OFS = 8'h08;

  // ==========================================================
  // control word fields
  localparam int DPR_CTRL_W = 6;
  localparam int DPR_CTRL_MODE_LO = 0;
  localparam int DPR_CTRL_SDP = 2;
  localparam int DPR_CTRL_OREG_A = 3;
  localparam int DPR_CTRL_OREG_B = 4;
  localparam int DPR_CTRL_SPLIT = 5;
  localparam logic [5:0] DPR_CTRL_RST = 6'h00;

  // ==========================================================
  // status word fields
  localparam int DPR_ST_MODE_LO = 0;
  localparam int DPR_ST_SDP = 2;
  localparam int DPR_ST_ADJ = 3;
  localparam int DPR_ST_SPLIT = 4;

  // ==========================================================
  // bus answers and sizing limits
  localparam logic [1:0] DPR_RESP_OKAY = 2'h0;
  localparam logic [1:0] DPR_RESP_SLVERR = 2'h2;
  localparam int DPR_SPLIT_MAX_BITS = 2048;

  // clocking modes, in control-field order
  typedef enum logic [1:0] {
    DPR_INDEP,
    DPR_INOUT,
    DPR_RDWR,
    DPR_SINGLE
  } dpr_mode_t;
endpackage

// >>> rtl/dpr_pin_sync.sv
// Purpose: two-stage synchroniser for a bundle of pin levels
// Assumes: each bit is a level that stays put for several clocks
// Notes: the first stage feeds only the second stage
`timescale 1ns/10ps
module dpr_pin_sync #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // ==========================================================
  // two flops, nothing taps the first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// >>> rtl/dpr_axil_regs.sv
// Purpose: AXI4-Lite slave holding control and showing status
// Assumes: one write and one read outstanding at most
// Notes: unmapped addresses answer SLVERR, reads of them give zero
`timescale 1ns/10ps
module dpr_axil_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [5:0] ctrl,
  input wire logic [31:0] status,
  input wire logic [31:0] wrcnt
);
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic aw_hit;

  // both halves held and no answer pending
  assign do_write = !awready && !wready && !bvalid;
  assign aw_hit = (aw_addr == dpr_pkg::DPR_CTRL_OFS) ||
                  (aw_addr == dpr_pkg::DPR_STATUS_OFS) ||
                  (aw_addr == dpr_pkg::DPR_WRCNT_OFS);

  // ==========================================================
  // write address and data, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_addr <= 8'h00;
    end else if (awvalid && awready) begin
      aw_addr <= awaddr;
      awready <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wvalid && wready) begin
      w_data <= wdata;
      w_strb <= wstrb;
      wready <= 1'b0;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  // response and control store; read-only words ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= dpr_pkg::DPR_RESP_OKAY;
      ctrl <= dpr_pkg::DPR_CTRL_RST;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= aw_hit ? dpr_pkg::DPR_RESP_OKAY : dpr_pkg::DPR_RESP_SLVERR;
      if (aw_addr == dpr_pkg::DPR_CTRL_OFS && w_strb[0]) begin
        ctrl <= w_data[5:0];
      end
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // read channel, data loaded on the same edge that takes the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= dpr_pkg::DPR_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= dpr_pkg::DPR_RESP_OKAY;
      case (araddr)
        dpr_pkg::DPR_CTRL_OFS: rdata <= {26'h000_0000, ctrl};
        dpr_pkg::DPR_STATUS_OFS: rdata <= status;
        dpr_pkg::DPR_WRCNT_OFS: rdata <= wrcnt;
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= dpr_pkg::DPR_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule

// >>> rtl/dpr_ram_top.sv
// Purpose: two-port memory with selectable clocking of its registers
// Assumes: port clocks arrive as pins far slower than aclk
// Notes: a port-clock edge is seen two aclk edges after the pin
`timescale 1ns/10ps
module dpr_ram_top #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] port_clk,
  input wire logic [1:0] in_ena,
  input wire logic [1:0] out_ena,
  input wire logic [1:0] in_clr,
  input wire logic [1:0] out_clr,
  input wire logic [ADDR_W-1:0] a_addr,
  input wire logic [DATA_W-1:0] a_wdata,
  input wire logic a_we,
  input wire logic a_re,
  input wire logic [ADDR_W-1:0] b_addr,
  input wire logic [DATA_W-1:0] b_wdata,
  input wire logic b_we,
  input wire logic b_re,
  output logic [DATA_W-1:0] a_rdata,
  output logic [DATA_W-1:0] b_rdata
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int PW = ADDR_W + DATA_W + 2;
  localparam int SW = 10 + 2 * PW;
  localparam bit SPLIT_LEGAL = (DEPTH / 2) * DATA_W <=
                               dpr_pkg::DPR_SPLIT_MAX_BITS;

  // ==========================================================
  // pin synchronisers
  logic [SW-1:0] pins_s;
  logic [1:0] clk_s, clk_prev, rise;
  logic [1:0] ien_s, oen_s, iclr_s, oclr_s;
  logic [ADDR_W-1:0] pin_addr [2];
  logic [DATA_W-1:0] pin_wdata [2];
  logic [1:0] pin_we, pin_re;

  dpr_pin_sync #(.W(SW)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({port_clk, in_ena, out_ena, in_clr, out_clr,
        a_addr, a_wdata, a_we, a_re, b_addr, b_wdata, b_we, b_re}),
    .q(pins_s)
  );

  // unpack the synchronised bundle
  assign {clk_s, ien_s, oen_s, iclr_s, oclr_s,
          pin_addr[0], pin_wdata[0], pin_we[0], pin_re[0],
          pin_addr[1], pin_wdata[1], pin_we[1], pin_re[1]} = pins_s;
  assign rise = clk_s & ~clk_prev;

  // edge detect on the already synchronised clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev <= 2'b00;
    end else begin
      clk_prev <= clk_s;
    end
  end

  // ==========================================================
  // register slave and effective configuration
  logic [5:0] ctrl;
  logic [15:0] wr_cnt [2];
  dpr_pkg::dpr_mode_t req_mode, cur_mode;
  logic cur_sdp, cur_adj, cur_split;
  logic [1:0] oreg_en;
  logic next_sdp, next_adj, next_split;

  dpr_axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .ctrl(ctrl),
    .status({27'h000_0000, cur_split, cur_adj, cur_sdp, cur_mode}),
    .wrcnt({wr_cnt[1], wr_cnt[0]})
  );

  assign req_mode = dpr_pkg::dpr_mode_t'(ctrl[1:0]);

  // illegal requests are coerced and flagged (SDP in single-port mode is cleared unflagged), never refused outright
  always_comb begin
    next_sdp = ctrl[dpr_pkg::DPR_CTRL_SDP];
    next_adj = 1'b0;
    next_split = 1'b0;
    case (req_mode)
      dpr_pkg::DPR_INDEP: begin
        next_sdp = 1'b0;
        next_adj = ctrl[dpr_pkg::DPR_CTRL_SDP];
      end
      dpr_pkg::DPR_INOUT: begin
        next_sdp = ctrl[dpr_pkg::DPR_CTRL_SDP];
      end
      dpr_pkg::DPR_RDWR: begin
        next_sdp = 1'b1;
        next_adj = !ctrl[dpr_pkg::DPR_CTRL_SDP];
      end
      dpr_pkg::DPR_SINGLE: begin
        next_sdp = 1'b0;
        next_split = ctrl[dpr_pkg::DPR_CTRL_SPLIT] && SPLIT_LEGAL;
        next_adj = ctrl[dpr_pkg::DPR_CTRL_SPLIT] && !SPLIT_LEGAL;
      end
      default: begin
        next_sdp = 1'b0;
      end
    endcase
    if (req_mode != dpr_pkg::DPR_SINGLE && ctrl[dpr_pkg::DPR_CTRL_SPLIT]) begin
      next_adj = 1'b1;
    end
  end

  // configuration takes effect one edge after the control write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_mode <= dpr_pkg::DPR_INDEP;
      cur_sdp <= 1'b0;
      cur_adj <= 1'b0;
      cur_split <= 1'b0;
      oreg_en <= 2'b00;
    end else begin
      cur_mode <= req_mode;
      cur_sdp <= next_sdp;
      cur_adj <= next_adj;
      cur_split <= next_split;
      oreg_en <= {ctrl[dpr_pkg::DPR_CTRL_OREG_B],
                  ctrl[dpr_pkg::DPR_CTRL_OREG_A]};
    end
  end

  // ==========================================================
  // per-port clock, enable and clear routing
  logic [1:0] in_sel, out_sel, in_ce, out_ce, in_cl, out_cl;
  logic [1:0] port_en, wr_ok, rd_ok, in_tick, out_tick;
  logic is_inout;

  // only input/output mode splits a port over two clocks
  always_comb begin
    is_inout = cur_mode == dpr_pkg::DPR_INOUT;
    for (int p = 0; p < 2; p++) begin
      in_sel[p] = is_inout ? 1'b0 : p[0];
      out_sel[p] = is_inout ? 1'b1 : p[0];
      in_ce[p] = ien_s[p];
      out_ce[p] = is_inout ? oen_s[p] : ien_s[p];
      in_cl[p] = iclr_s[p];
      out_cl[p] = is_inout ? oclr_s[p] : iclr_s[p];
      port_en[p] = (p == 0) || cur_mode != dpr_pkg::DPR_SINGLE ||
                   cur_split;
      wr_ok[p] = !cur_sdp || p == 0;
      rd_ok[p] = !cur_sdp || p == 1;
      in_tick[p] = rise[in_sel[p]] && in_ce[p] && port_en[p] &&
                   !in_cl[p];
      out_tick[p] = rise[out_sel[p]] && out_ce[p] && !out_cl[p];
    end
  end

  // ==========================================================
  // input registers: one clock loads all of a port's registers
  logic [ADDR_W-1:0] addr_q [2];
  logic [DATA_W-1:0] wdata_q [2];
  logic [1:0] we_q, re_q, pend;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < 2; p++) begin
        addr_q[p] <= '0;
        wdata_q[p] <= '0;
      end
      we_q <= 2'b00;
      re_q <= 2'b00;
      pend <= 2'b00;
    end else begin
      pend <= in_tick;
      for (int p = 0; p < 2; p++) begin
        if (in_cl[p]) begin
          addr_q[p] <= '0;
          wdata_q[p] <= '0;
          we_q[p] <= 1'b0;
          if (!cur_sdp) begin
            re_q[p] <= 1'b0;
          end
        end else if (in_tick[p]) begin
          addr_q[p] <= pin_addr[p];
          wdata_q[p] <= pin_wdata[p];
          we_q[p] <= pin_we[p] && wr_ok[p];
          re_q[p] <= pin_re[p] && rd_ok[p];
        end
      end
    end
  end

  // ==========================================================
  // storage array; a split puts port B in the upper half
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] mem_q [2];
  logic [DATA_W-1:0] dout [2];
  logic [ADDR_W-1:0] ea [2];
  logic [1:0] wr_fire, rd_fire;

  function automatic logic [ADDR_W-1:0] eff_addr(
    input logic split,
    input logic half,
    input logic [ADDR_W-1:0] a
  );
    eff_addr = split ? {half, a[ADDR_W-2:0]} : a;
  endfunction

  assign ea[0] = eff_addr(cur_split, 1'b0, addr_q[0]);
  assign ea[1] = eff_addr(cur_split, 1'b1, addr_q[1]);
  assign wr_fire = pend & we_q;
  assign rd_fire = pend & re_q;

  // same-location writes from both ports: port B lands last
  always_ff @(posedge aclk) begin
    for (int p = 0; p < 2; p++) begin
      if (wr_fire[p]) begin
        mem[ea[p]] <= wdata_q[p];
      end
    end
  end

  // read latch of the array, cleared with the input side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (in_cl[p]) begin
          mem_q[p] <= '0;
        end else if (rd_fire[p]) begin
          mem_q[p] <= mem[ea[p]];
        end
      end
    end
  end

  // output register; bypass still costs one aclk so pins stay flopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout[0] <= '0;
      dout[1] <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (out_cl[p]) begin
          dout[p] <= '0;
        end else if (!oreg_en[p]) begin
          dout[p] <= mem_q[p];
        end else if (out_tick[p]) begin
          dout[p] <= mem_q[p];
        end
      end
    end
  end

  assign a_rdata = dout[0];
  assign b_rdata = dout[1];

  // write counters, wrap silently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_cnt[0] <= 16'h0000;
      wr_cnt[1] <= 16'h0000;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (wr_fire[p]) begin
          wr_cnt[p] <= wr_cnt[p] + 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_cap_a;
    in_tick[0] && pin_we[0] && wr_ok[0];
  endsequence

  sequence s_write_a;
    pend[0] && we_q[0] ##1 wr_cnt[0] == $past(wr_cnt[0]) + 16'h0001;
  endsequence

  property p_indep_tdp;
    cur_mode == dpr_pkg::DPR_INDEP |-> !cur_sdp;
  endproperty
  a_indep_tdp: assert property (p_indep_tdp)
    else $error("independent mode with split ports");

  property p_indep_clk_b;
    in_tick[1] && !is_inout |-> rise[1];
  endproperty
  a_indep_clk_b: assert property (p_indep_clk_b)
    else $error("port B loaded without its own clock");

  property p_hold;
    !in_tick[0] && !in_cl[0] |=> $stable(addr_q[0]) && $stable(we_q[0]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("input register moved while disabled");

  property p_tdp_clear;
    in_cl[1] && !cur_sdp |=> !re_q[1] && !we_q[1] && addr_q[1] == '0;
  endproperty
  a_tdp_clear: assert property (p_tdp_clear)
    else $error("clear missed a register");

  property p_inout_out_clk;
    out_tick[0] && is_inout |-> rise[1] && oen_s[0];
  endproperty
  a_inout_out_clk: assert property (p_inout_out_clk)
    else $error("output register off the output clock");

  property p_out_clear;
    out_cl[0] |=> dout[0] == '0;
  endproperty
  a_out_clear: assert property (p_out_clear)
    else $error("output clear ignored");

  property p_sdp_roles;
    cur_sdp |-> !wr_fire[1] && !rd_fire[0];
  endproperty
  a_sdp_roles: assert property (p_sdp_roles)
    else $error("port role broken in split mode");

  property p_rden_noclr;
    cur_sdp && in_cl[1] |=> re_q[1] == $past(re_q[1]);
  endproperty
  a_rden_noclr: assert property (p_rden_noclr)
    else $error("read strobe register cleared");

  property p_bypass;
    !oreg_en[0] && !out_cl[0] |=> dout[0] == $past(mem_q[0]);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypassed output lagged");

  property p_split_half;
    wr_fire[1] && cur_split |-> ea[1][ADDR_W-1];
  endproperty
  a_split_half: assert property (p_split_half)
    else $error("split port B outside upper half");

  property p_single_b_idle;
    cur_mode == dpr_pkg::DPR_SINGLE && !cur_split |-> !in_tick[1];
  endproperty
  a_single_b_idle: assert property (p_single_b_idle)
    else $error("port B active in single-port mode");

  property p_capture;
    s_cap_a |=> s_write_a;
  endproperty
  a_capture: assert property (p_capture)
    else $error("captured write not performed");
endmodule

// >>> tb/dpr_user_model.sv
// Purpose: user logic on both memory ports, with its two slow clocks
// Assumes: each port-clock phase lasts at least six aclk periods
// Notes: released address and data show the inverse of the last value, strobes go low
`timescale 1ns/10ps
module dpr_user_model (
  input wire logic aclk,
  output logic [1:0] port_clk,
  output logic [7:0] a_addr,
  output logic [15:0] a_wdata,
  output logic a_we,
  output logic a_re,
  output logic [7:0] b_addr,
  output logic [15:0] b_wdata,
  output logic b_we,
  output logic b_re
);
  // ==========================================
  // idle levels
  initial begin
    port_clk = 2'h0;
    {a_addr, a_wdata, a_we, a_re} = 26'h0;
    {b_addr, b_wdata, b_we, b_re} = 26'h0;
  end

  // ==========================================
  // one clock pulse; long phases so the pin synchroniser sees it
  task automatic pulse(input int ck);
    repeat (4) @(posedge aclk);
    port_clk[ck] <= 1'b1;
    repeat (6) @(posedge aclk);
    port_clk[ck] <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask

  // one access; inputs held across the whole pulse of clock ck
  task automatic op(input bit pb, input logic we, input logic re,
      input logic [7:0] ad, input logic [15:0] d, input int ck);
    @(posedge aclk);
    if (pb) begin
      {b_addr, b_wdata, b_we, b_re} <= {ad, d, we, re};
    end else begin
      {a_addr, a_wdata, a_we, a_re} <= {ad, d, we, re};
    end
    pulse(ck);
    // stale values must not look valid after release
    if (pb) begin
      {b_addr, b_wdata, b_we, b_re} <= {~ad, ~d, 2'h0};
    end else begin
      {a_addr, a_wdata, a_we, a_re} <= {~ad, ~d, 2'h0};
    end
  endtask
endmodule

// >>> tb/dual_port_ram_clock_modes_test.sv
// Purpose: self-checking bench of the clock-mode memory block
// Assumes: default sizes, 8 address bits and 16 data bits
// Notes: bus answers are taken at the rising edge that completes them
`timescale 1ns/10ps
module dual_port_ram_clock_modes_test;
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [1:0] in_ena, out_ena, in_clr, out_clr, port_clk;
  logic [7:0] a_addr, b_addr;
  logic [15:0] a_wdata, b_wdata, a_rdata, b_rdata;
  logic a_we, a_re, b_we, b_re;
  logic [31:0] d;
  logic [1:0] r;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;

  // ==========================================
  // clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  dpr_ram_top #(.ADDR_W(8), .DATA_W(16)) dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_clk(port_clk), .in_ena(in_ena), .out_ena(out_ena),
    .in_clr(in_clr), .out_clr(out_clr),
    .a_addr(a_addr), .a_wdata(a_wdata), .a_we(a_we), .a_re(a_re),
    .b_addr(b_addr), .b_wdata(b_wdata), .b_we(b_we), .b_re(b_re),
    .a_rdata(a_rdata), .b_rdata(b_rdata));

  dpr_user_model user_u (
    .aclk(aclk), .port_clk(port_clk),
    .a_addr(a_addr), .a_wdata(a_wdata), .a_we(a_we), .a_re(a_re),
    .b_addr(b_addr), .b_wdata(b_wdata), .b_we(b_we), .b_re(b_re));

  // ==========================================
  // comparison and closing report
  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================
  // bus master; address and data offered together, each freed when taken
  // pre-edge values are read right after each rising edge
  task automatic axw(input logic [7:0] a, input logic [31:0] v,
      output logic [1:0] rs);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    {awvalid, wvalid, bready} <= 3'h7;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      done = bvalid;
      rs = bresp;
    end
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v,
      output logic [1:0] rs);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      done = rvalid;
      v = rdata;
      rs = rresp;
    end
    rready <= 1'b0;
  endtask

  // set the mode word, then compare the status word
  task automatic ctrl_st(input logic [5:0] c, input logic [31:0] st);
    axw(dpr_pkg::DPR_CTRL_OFS, {26'h0, c}, r);
    axr(dpr_pkg::DPR_STATUS_OFS, d, r);
    check("status", d, st);
  endtask

  // clear pulse long enough to pass the level synchroniser
  task automatic clr(input logic [1:0] ic, input logic [1:0] oc);
    @(posedge aclk);
    {in_clr, out_clr} <= {ic, oc};
    repeat (6) @(posedge aclk);
    {in_clr, out_clr} <= 4'h0;
    repeat (6) @(posedge aclk);
  endtask

  // ==========================================
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 48'h0;
    {in_ena, out_ena, in_clr, out_clr} = 8'hF0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(dpr_pkg::DPR_CTRL_OFS, d, r);
    check("ctrl_reset", d, 32'h0);
    axr(8'h0C, d, r);
    check("unmapped_rd", {d[29:0], r}, {30'h0, dpr_pkg::DPR_RESP_SLVERR});
    axw(8'h10, 32'h1, r);
    check("unmapped_wr", {30'h0, r}, {30'h0, dpr_pkg::DPR_RESP_SLVERR});
    axw(dpr_pkg::DPR_STATUS_OFS, 32'hFF, r);
    check("ro_write", {30'h0, r}, {30'h0, dpr_pkg::DPR_RESP_OKAY});
    ctrl_st(6'h04, 32'h08);
    ctrl_st(6'h02, 32'h0E);
    ctrl_st(6'h05, 32'h05);
    ctrl_st(6'h01, 32'h01);
    ctrl_st(6'h23, 32'h13);
    ctrl_st(6'h00, 32'h00);
    // independent clocks: write on A with clock A, read on B with clock B
    user_u.op(0, 1, 0, 8'h05, 16'h1234, 0);
    user_u.op(1, 0, 1, 8'h05, 16'h0000, 1);
    check("indep_rd", {16'h0, b_rdata}, 32'h1234);
    // B disabled: holds its output, yet its clear still acts
    in_ena <= 2'h1;
    user_u.op(0, 1, 0, 8'h06, 16'h5A5A, 0);
    user_u.op(1, 0, 1, 8'h06, 16'h0000, 1);
    check("b_hold", {16'h0, b_rdata}, 32'h1234);
    clr(2'h2, 2'h0);
    check("b_clear", {16'h0, b_rdata}, 32'h0);
    in_ena <= 2'h3;
    user_u.op(1, 1, 0, 8'h07, 16'hABCD, 1);
    axr(dpr_pkg::DPR_WRCNT_OFS, d, r);
    check("wrcnt", d, 32'h00010002);
    // read/write clocks: write side on clock 0, read side on clock 1
    ctrl_st(6'h06, 32'h06);
    user_u.op(0, 1, 0, 8'h09, 16'hC3C3, 0);
    user_u.op(1, 0, 1, 8'h09, 16'h0000, 1);
    check("rdwr_rd", {16'h0, b_rdata}, 32'hC3C3);
    clr(2'h2, 2'h0);
    check("rdwr_clr", {16'h0, b_rdata}, 32'h0);
    // input/output clocks with registered B output
    ctrl_st(6'h11, 32'h01);
    user_u.op(1, 0, 1, 8'h06, 16'h0000, 0);
    user_u.pulse(1);
    check("io_rd", {16'h0, b_rdata}, 32'h5A5A);
    clr(2'h0, 2'h2);
    check("io_oclr", {16'h0, b_rdata}, 32'h0);
    user_u.op(1, 0, 1, 8'h09, 16'h0000, 0);
    check("io_wait", {16'h0, b_rdata}, 32'h0);
    user_u.pulse(1);
    check("io_out", {16'h0, b_rdata}, 32'hC3C3);
    // single port: write then read on the shared port
    ctrl_st(6'h03, 32'h03);
    user_u.op(0, 1, 0, 8'h20, 16'h0F0F, 0);
    user_u.op(0, 0, 1, 8'h20, 16'h0000, 0);
    check("single_rd", {16'h0, a_rdata}, 32'h0F0F);
    // split single port: B in the upper half, A output registered
    ctrl_st(6'h2B, 32'h13);
    user_u.op(1, 1, 0, 8'h20, 16'h7E7E, 1);
    user_u.op(1, 0, 1, 8'h20, 16'h0000, 1);
    check("split_b", {16'h0, b_rdata}, 32'h7E7E);
    // top address bit of A dropped: 0x85 lands on word 0x05
    user_u.op(0, 0, 1, 8'h85, 16'h0000, 0);
    check("oreg_wait", {16'h0, a_rdata}, 32'h0F0F);
    user_u.pulse(0);
    check("split_a", {16'h0, a_rdata}, 32'h1234);
    end_of_test();
  end
endmodule
